// *** rtl/ccd_top.sv ***
// Configuration window decoder: ROM area, config RAM and register area
`timescale 1ns/10ps
module ccd_top #(
   parameter int NUM_FUNC = 2,
   parameter int RAM_DEPTH = 256,
   parameter int RAM_AW = 8
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [4:0] GA,
   input wire logic REQ,
   input wire ccd_pkg::ccd_req_s REQ_BUS,
   output logic ACK,
   output logic [7:0] ACK_DATA,
   output logic MODULE_EN,
   output logic [NUM_FUNC-1:0][31:0] FUNC_ADER,
   output logic [NUM_FUNC-1:0] FUNC_HIT,
   output logic [7:0] RAM_OWNER
);
   //-------------------------------------------------------------------
   // Declarations
   //-------------------------------------------------------------------
   localparam logic [18:0] RAM_LIM =
      19'(int'(ccd_pkg::RAM_START) + ccd_pkg::BYTE_STRIDE * RAM_DEPTH);

   ccd_pkg::ccd_phase_e phase;
   ccd_pkg::ccd_phase_e next_phase;
   ccd_pkg::ccd_stage_s stage;
   ccd_pkg::ccd_stage_s next_stage;
   logic [ccd_pkg::BAR_W-1:0] bar;
   logic bar_loaded;
   logic take;
   logic in_win;
   logic [18:0] req_off;
   logic [18:0] ram_rel;
   logic [18:0] stg_rel;
   logic [7:0] rom_data;
   logic [7:0] ram_data;
   logic [7:0] csr_rd;
   logic lane_ok;
   logic ram_we;
   logic csr_wr;
   logic owned;

   //-------------------------------------------------------------------
   // Request acceptance and window decode
   //-------------------------------------------------------------------
   // One request in flight; none before the base register is loaded
   assign take = REQ && (phase == ccd_pkg::PH_IDLE) && bar_loaded;
   assign req_off = REQ_BUS.addr[18:0];
   // Window hit needs the config modifier and our slot's base
   assign in_win = (REQ_BUS.am == ccd_pkg::AM_CONFIG) &&
      (REQ_BUS.addr[23:ccd_pkg::BAR_LO] == bar);
   assign ram_rel = req_off - ccd_pkg::RAM_START;
   assign stg_rel = stage.off - ccd_pkg::RAM_START;

   // Area classification of the accepted offset
   always_comb begin
      next_stage = stage;
      next_stage.hit = 1'b0;
      if (take) begin
         next_stage.hit = in_win;
         next_stage.write = REQ_BUS.write;
         next_stage.off = req_off;
         next_stage.wdata = REQ_BUS.wdata;
         if (req_off <= ccd_pkg::ROM_END) begin
            next_stage.area = ccd_pkg::AREA_ROM;
         end else if ((req_off >= ccd_pkg::RAM_START) && (req_off < RAM_LIM)) begin
            next_stage.area = ccd_pkg::AREA_RAM;
         end else if (req_off >= ccd_pkg::CSR_AREA_LO) begin
            next_stage.area = ccd_pkg::AREA_CSR;
         end else begin
            next_stage.area = ccd_pkg::AREA_NONE;
         end
      end
   end

   // Phase sequencing
   always_comb begin
      next_phase = phase;
      unique case (phase)
         ccd_pkg::PH_IDLE: begin
            if (take) begin
               next_phase = ccd_pkg::PH_LOOK;
            end
         end
         ccd_pkg::PH_LOOK: begin
            next_phase = ccd_pkg::PH_IDLE;
         end
      endcase
   end

   // Phase and stage registers
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         phase <= ccd_pkg::PH_IDLE;
         stage <= '0;
      end else begin
         phase <= next_phase;
         stage <= next_stage;
      end
   end

   //-------------------------------------------------------------------
   // Base address from the slot
   //-------------------------------------------------------------------
   // Slot address caught on the first edge after reset release
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         bar <= '0;
         bar_loaded <= 1'b0;
      end else if (!bar_loaded) begin
         bar <= GA;
         bar_loaded <= 1'b1;
      end
   end

   //-------------------------------------------------------------------
   // ROM and config RAM
   //-------------------------------------------------------------------
   ccd_rom u_rom (
      .clk(CLK),
      .rd_idx(req_off[11:2]),
      .rd_data(rom_data)
   );

   // Only the odd byte of every fourth location carries data
   assign lane_ok = (stage.off[1:0] == ccd_pkg::LANE_ODD);
   assign csr_wr = (phase == ccd_pkg::PH_LOOK) && stage.hit && stage.write &&
      (stage.area == ccd_pkg::AREA_CSR) && lane_ok;
   // RAM writes taken in owner-free or owned state alike, no owner check
   assign ram_we = (phase == ccd_pkg::PH_LOOK) && stage.hit && stage.write &&
      (stage.area == ccd_pkg::AREA_RAM) && lane_ok;

   ccd_ram #(
      .DEPTH(RAM_DEPTH),
      .AW(RAM_AW)
   ) u_ram (
      .clk(CLK),
      .wr_en(ram_we),
      .wr_idx(stg_rel[RAM_AW+1:2]),
      .wr_data(stage.wdata),
      .rd_idx(ram_rel[RAM_AW+1:2]),
      .rd_data(ram_data)
   );

   //-------------------------------------------------------------------
   // Register area
   //-------------------------------------------------------------------
   assign owned = (RAM_OWNER != ccd_pkg::OWNER_FREE);

   // Read mux of the register area
   always_comb begin
      csr_rd = ccd_pkg::BYTE_ZERO;
      unique case (stage.off)
         ccd_pkg::CSR_BAR: csr_rd = {bar, 3'h0};
         ccd_pkg::CSR_BIT_SET, ccd_pkg::CSR_BIT_CLR: begin
            csr_rd[ccd_pkg::BIT_MOD_EN] = MODULE_EN;
            csr_rd[ccd_pkg::BIT_RAM_OWNED] = owned;
         end
         ccd_pkg::CSR_RAM_OWNER: csr_rd = RAM_OWNER;
         default: csr_rd = ccd_pkg::BYTE_ZERO;
      endcase
      for (int f = 0; f < NUM_FUNC; f++) begin
         for (int k = 0; k < 4; k++) begin
            if (stage.off == 19'(int'(ccd_pkg::CSR_ADER_BASE) +
                  f * ccd_pkg::ADER_STRIDE + k * ccd_pkg::BYTE_STRIDE)) begin
               csr_rd = FUNC_ADER[f][31-8*k -: 8];
            end
         end
      end
   end

   // Module enable through bit set and bit clear
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         MODULE_EN <= 1'b0;
      end else if (csr_wr && stage.wdata[ccd_pkg::BIT_MOD_EN]) begin
         if (stage.off == ccd_pkg::CSR_BIT_SET) begin
            MODULE_EN <= 1'b1;
         end else if (stage.off == ccd_pkg::CSR_BIT_CLR) begin
            MODULE_EN <= 1'b0;
         end
      end
   end

   // Config RAM owner: claimed only while free, freed by bit clear
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         RAM_OWNER <= ccd_pkg::OWNER_FREE;
      end else if (csr_wr && (stage.off == ccd_pkg::CSR_RAM_OWNER) && !owned) begin
         RAM_OWNER <= stage.wdata;
      end else if (csr_wr && (stage.off == ccd_pkg::CSR_BIT_CLR) &&
            stage.wdata[ccd_pkg::BIT_RAM_OWNED]) begin
         RAM_OWNER <= ccd_pkg::OWNER_FREE;
      end
   end

   //-------------------------------------------------------------------
   // Relocated spaces: base registers and hit decode
   //-------------------------------------------------------------------
   for (genvar f = 0; f < NUM_FUNC; f++) begin : g_func
      // Big-endian bytes of this function's base register
      always_ff @(posedge CLK) begin
         if (!RST_N) begin
            FUNC_ADER[f] <= ccd_pkg::ADER_RST;
         end else if (csr_wr) begin
            for (int k = 0; k < 4; k++) begin
               if (stage.off == 19'(int'(ccd_pkg::CSR_ADER_BASE) +
                     f * ccd_pkg::ADER_STRIDE + k * ccd_pkg::BYTE_STRIDE)) begin
                  FUNC_ADER[f][31-8*k -: 8] <= stage.wdata;
               end
            end
         end
      end

      // Hit pulse for a relocated access, held off until enabled
      always_ff @(posedge CLK) begin
         if (!RST_N) begin
            FUNC_HIT[f] <= 1'b0;
         end else begin
            FUNC_HIT[f] <= take && MODULE_EN &&
               (REQ_BUS.am != ccd_pkg::AM_CONFIG) &&
               (REQ_BUS.am == FUNC_ADER[f][ccd_pkg::ADER_AM_LO +: 6]) &&
               (REQ_BUS.addr[31:ccd_pkg::ADER_CMP_LO] ==
                FUNC_ADER[f][31:ccd_pkg::ADER_CMP_LO]);
         end
      end
   end

   //-------------------------------------------------------------------
   // Answer
   //-------------------------------------------------------------------
   // Acknowledge every window hit; writes read back zero
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ACK <= 1'b0;
         ACK_DATA <= ccd_pkg::BYTE_ZERO;
      end else begin
         ACK <= (phase == ccd_pkg::PH_LOOK) && stage.hit;
         ACK_DATA <= ccd_pkg::BYTE_ZERO;
         if ((phase == ccd_pkg::PH_LOOK) && stage.hit && !stage.write && lane_ok) begin
            unique case (stage.area)
               ccd_pkg::AREA_ROM: ACK_DATA <= rom_data;
               ccd_pkg::AREA_RAM: ACK_DATA <= ram_data;
               ccd_pkg::AREA_CSR: ACK_DATA <= csr_rd;
               ccd_pkg::AREA_NONE: ACK_DATA <= ccd_pkg::BYTE_ZERO;
            endcase
         end
      end
   end
endmodule

// *** rtl/ccd_pkg.sv ***
// Constants, types and field layout of the configuration window decoder
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
package ccd_pkg;
   //-------------------------------------------------------------------
   // Window decode
   //-------------------------------------------------------------------
   localparam int OFF_W = 19;
   localparam logic [5:0] AM_CONFIG = 6'h2f;
   localparam logic [18:0] WIN_TOP = 19'h7ffff;
   localparam logic [18:0] ROM_END = 19'h00fff;
   localparam logic [18:0] CSR_AREA_LO = 19'h7fc00;
   localparam logic [1:0] LANE_ODD = 2'h3;
   localparam int BAR_LO = 19;
   localparam int BAR_W = 5;
   //-------------------------------------------------------------------
   // Register offsets and bits
   //-------------------------------------------------------------------
   localparam logic [18:0] CSR_BAR = 19'h7ffff;
   localparam logic [18:0] CSR_BIT_SET = 19'h7fffb;
   localparam logic [18:0] CSR_BIT_CLR = 19'h7fff7;
   localparam logic [18:0] CSR_RAM_OWNER = 19'h7fff3;
   localparam logic [18:0] CSR_ADER_BASE = 19'h7ff63;
   localparam int ADER_STRIDE = 16;
   localparam int BYTE_STRIDE = 4;
   localparam int BIT_MOD_EN = 4;
   localparam int BIT_RAM_OWNED = 2;
   localparam int ADER_AM_LO = 2;
   localparam int ADER_CMP_LO = 16;
   localparam logic [31:0] ADER_RST = 32'h0000_0000;
   localparam logic [7:0] OWNER_FREE = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   //-------------------------------------------------------------------
   // Config RAM placement
   //-------------------------------------------------------------------
   localparam logic [18:0] RAM_START = 19'h01003;
   //-------------------------------------------------------------------
   // ROM contents
   //-------------------------------------------------------------------
   localparam logic [18:0] ROM_SPEC_ID = 19'h0001b;
   localparam logic [7:0] SPEC_ID_VAL = 8'h02;
   localparam logic [18:0] ROM_ASCII_C = 19'h0001f;
   localparam logic [18:0] ROM_ASCII_R = 19'h00023;
   localparam logic [7:0] ASCII_C = 8'h43;
   localparam logic [7:0] ASCII_R = 8'h52;
   localparam logic [18:0] ROM_MFR_ID = 19'h00027;
   localparam logic [23:0] MFR_ID_VAL = 24'h00_12_34; // Arbitrary value
   localparam logic [18:0] ROM_SER_BEG = 19'h000cb;
   localparam logic [18:0] ROM_SER_END = 19'h000d7;
   localparam logic [23:0] SER_BEG_VAL = 24'h00_0e03;
   localparam logic [23:0] SER_END_VAL = 24'h00_0e0f;
   localparam logic [31:0] SERIAL_VAL = 32'h0000_0001; // Arbitrary value
   //-------------------------------------------------------------------
   // Types
   //-------------------------------------------------------------------
   typedef struct packed {
      logic write;
      logic [5:0] am;
      logic [31:0] addr;
      logic [7:0] wdata;
   } ccd_req_s;
   typedef enum logic [1:0] {
      PH_IDLE = 2'b01,
      PH_LOOK = 2'b10
   } ccd_phase_e;
   typedef enum logic [1:0] {
      AREA_NONE = 2'h0,
      AREA_ROM = 2'h1,
      AREA_RAM = 2'h2,
      AREA_CSR = 2'h3
   } ccd_area_e;
   typedef struct packed {
      logic hit;
      logic write;
      ccd_area_e area;
      logic [18:0] off;
      logic [7:0] wdata;
   } ccd_stage_s;
endpackage

// *** rtl/ccd_rom.sv ***
// Constant configuration ROM table with registered read data
`timescale 1ns/10ps
module ccd_rom (
   input wire logic clk,
   input wire logic [9:0] rd_idx,
   output logic [7:0] rd_data
);
   //-------------------------------------------------------------------
   // Table lookup
   //-------------------------------------------------------------------
   // Byte at odd lane of word idx; unlisted locations are zero
   function automatic logic [7:0] rom_byte(input logic [9:0] idx);
      logic [18:0] off;
      logic [7:0] val;
      off = {7'h00, idx, ccd_pkg::LANE_ODD};
      val = ccd_pkg::BYTE_ZERO;
      unique case (off)
         ccd_pkg::ROM_SPEC_ID: val = ccd_pkg::SPEC_ID_VAL;
         ccd_pkg::ROM_ASCII_C: val = ccd_pkg::ASCII_C;
         ccd_pkg::ROM_ASCII_R: val = ccd_pkg::ASCII_R;
         ccd_pkg::ROM_MFR_ID: val = ccd_pkg::MFR_ID_VAL[23:16];
         ccd_pkg::ROM_MFR_ID + 19'h4: val = ccd_pkg::MFR_ID_VAL[15:8];
         ccd_pkg::ROM_MFR_ID + 19'h8: val = ccd_pkg::MFR_ID_VAL[7:0];
         ccd_pkg::ROM_SER_BEG: val = ccd_pkg::SER_BEG_VAL[23:16];
         ccd_pkg::ROM_SER_BEG + 19'h4: val = ccd_pkg::SER_BEG_VAL[15:8];
         ccd_pkg::ROM_SER_BEG + 19'h8: val = ccd_pkg::SER_BEG_VAL[7:0];
         ccd_pkg::ROM_SER_END: val = ccd_pkg::SER_END_VAL[23:16];
         ccd_pkg::ROM_SER_END + 19'h4: val = ccd_pkg::SER_END_VAL[15:8];
         ccd_pkg::ROM_SER_END + 19'h8: val = ccd_pkg::SER_END_VAL[7:0];
         ccd_pkg::SER_BEG_VAL[18:0]: val = ccd_pkg::SERIAL_VAL[31:24];
         ccd_pkg::SER_BEG_VAL[18:0] + 19'h4: val = ccd_pkg::SERIAL_VAL[23:16];
         ccd_pkg::SER_BEG_VAL[18:0] + 19'h8: val = ccd_pkg::SERIAL_VAL[15:8];
         ccd_pkg::SER_END_VAL[18:0]: val = ccd_pkg::SERIAL_VAL[7:0];
         default: val = ccd_pkg::BYTE_ZERO;
      endcase
      return val;
   endfunction

   // Registered read, contents fixed by constants
   always_ff @(posedge clk) begin
      rd_data <= rom_byte(rd_idx);
   end
endmodule

// *** rtl/ccd_ram.sv ***
// Byte-wide configuration RAM with registered read data
`timescale 1ns/10ps
module ccd_ram #(
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_idx,
   input wire logic [7:0] wr_data,
   input wire logic [AW-1:0] rd_idx,
   output logic [7:0] rd_data
);
   logic [7:0] mem [DEPTH];

   // Write port
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   // Read port
   always_ff @(posedge clk) begin
      rd_data <= mem[rd_idx];
   end
endmodule

// *** testbench/ccd_top_asserts.sv ***
// Port checker for the configuration window decoder, with its bind
`timescale 1ns/10ps
module ccd_top_asserts #(
   parameter int NUM_FUNC = 2,
   parameter int RAM_DEPTH = 256,
   parameter int RAM_AW = 8
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [4:0] GA,
   input wire logic REQ,
   input wire ccd_pkg::ccd_req_s REQ_BUS,
   input wire logic ACK,
   input wire logic [7:0] ACK_DATA,
   input wire logic MODULE_EN,
   input wire logic [NUM_FUNC-1:0][31:0] FUNC_ADER,
   input wire logic [NUM_FUNC-1:0] FUNC_HIT,
   input wire logic [7:0] RAM_OWNER
);
   logic rdy;
   logic busy;
   logic [4:0] ga_cap;
   logic taken;
   logic tk_hit;
   logic rd_hit;
   logic [18:0] off;
   // Which request edges the decoder takes
   assign taken = REQ && rdy && !busy;
   assign off = REQ_BUS.addr[18:0];
   assign tk_hit = taken && REQ_BUS.am == ccd_pkg::AM_CONFIG && REQ_BUS.addr[23:19] == ga_cap;
   assign rd_hit = tk_hit && !REQ_BUS.write;
   // Base is loaded on the first edge after release
   always_ff @(posedge CLK) begin
      rdy <= RST_N;
   end
   // Slot address caught once, like the decoder
   always_ff @(posedge CLK) begin
      if (RST_N && !rdy) begin
         ga_cap <= GA;
      end
   end
   // Cycle after a take is busy
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         busy <= 1'b0;
      end else begin
         busy <= taken;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   property p_ack_lat;
      tk_hit |-> ##2 ACK;
   endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("window request not answered");
   property p_ack_cause;
      ACK |-> $past(tk_hit, 2);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("answer without hit");
   property p_wr_zero;
      tk_hit && REQ_BUS.write |-> ##2 ACK && ACK_DATA == ccd_pkg::BYTE_ZERO;
   endproperty
   a_wr_zero: assert property (p_wr_zero) else $error("write answer not clean");
   property p_spec;
      rd_hit && off == ccd_pkg::ROM_SPEC_ID |-> ##2 ACK_DATA == ccd_pkg::SPEC_ID_VAL;
   endproperty
   a_spec: assert property (p_spec) else $error("spec id byte altered");
   property p_lane;
      rd_hit && off[1:0] != ccd_pkg::LANE_ODD |-> ##2 ACK_DATA == 8'h00;
   endproperty
   a_lane: assert property (p_lane) else $error("even lane read not zero");
   property p_rsv;
      rd_hit && off >= 19'h00100 && off <= 19'h00dff |-> ##2 ACK_DATA == 8'h00;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved byte not zero");
   property p_bar;
      rd_hit && off == ccd_pkg::CSR_BAR |-> ##2 ACK_DATA == {ga_cap, 3'b000};
   endproperty
   a_bar: assert property (p_bar) else $error("base register wrong");
   property p_en_rst;
      $past(RST_N) == 1'b0 |-> !MODULE_EN && RAM_OWNER == 8'h00 && FUNC_ADER == '0;
   endproperty
   a_en_rst: assert property (p_en_rst) else $error("state not cleared by reset");
   property p_en_set;
      tk_hit && REQ_BUS.write && off == ccd_pkg::CSR_BIT_SET && REQ_BUS.wdata[4] |-> ##2 MODULE_EN;
   endproperty
   a_en_set: assert property (p_en_set) else $error("enable not set");
   property p_hit_lat;
      taken && MODULE_EN && REQ_BUS.am == FUNC_ADER[0][7:2]
         && REQ_BUS.addr[31:16] == FUNC_ADER[0][31:16] |-> ##1 FUNC_HIT[0];
   endproperty
   a_hit_lat: assert property (p_hit_lat) else $error("relocated hit missed");
   property p_hit_gate;
      FUNC_HIT != '0 |-> $past(MODULE_EN);
   endproperty
   a_hit_gate: assert property (p_hit_gate) else $error("hit while disabled");
   c_ack: cover property (ACK);
   c_hit: cover property (FUNC_HIT[0]);
   c_en: cover property ($rose(MODULE_EN));
endmodule

bind ccd_top ccd_top_asserts #(.NUM_FUNC(NUM_FUNC), .RAM_DEPTH(RAM_DEPTH), .RAM_AW(RAM_AW))
   ccd_top_asserts_inst (.CLK(CLK), .RST_N(RST_N), .GA(GA), .REQ(REQ), .REQ_BUS(REQ_BUS),
   .ACK(ACK), .ACK_DATA(ACK_DATA), .MODULE_EN(MODULE_EN), .FUNC_ADER(FUNC_ADER),
   .FUNC_HIT(FUNC_HIT), .RAM_OWNER(RAM_OWNER));

// *** testbench/ccd_master.sv ***
// Bus master model issuing configuration and relocated cycles
`timescale 1ns/10ps
module ccd_master (
   input wire logic clk,
   input wire logic [4:0] ga,
   input wire logic ack,
   input wire logic [7:0] ack_data,
   input wire logic hit,
   output logic req,
   output ccd_pkg::ccd_req_s req_bus
);
   initial begin
      req = 1'b0;
      req_bus = '0;
   end
   // One request pulse; hit seen in cycle 1, answer in cycle 2
   task automatic xfer(input logic w, input logic [5:0] am, input logic [31:0] addr,
         input logic [7:0] wd, output logic got_ack, output logic [7:0] rd, output logic got_hit);
      @(negedge clk);
      req = 1'b1;
      req_bus = '{write: w, am: am, addr: addr, wdata: wd};
      @(negedge clk);
      req = 1'b0;
      req_bus = ~req_bus; // Released lines show no stale value
      got_hit = hit;
      @(negedge clk);
      got_ack = ack;
      rd = ack_data;
   endtask
   // Byte access to own window
   task automatic cfg(input logic w, input logic [18:0] off, input logic [7:0] wd,
         output logic got_ack, output logic [7:0] rd);
      logic h;
      xfer(w, ccd_pkg::AM_CONFIG, {8'h00, ga, off}, wd, got_ack, rd, h);
   endtask
   // Multi-byte read, stride four, most significant byte first
   task automatic rd_be(input logic [18:0] off, input int n, output logic [31:0] val);
      logic a;
      logic [7:0] b;
      val = '0;
      for (int k = 0; k < n; k++) begin
         cfg(1'b0, off + 19'(ccd_pkg::BYTE_STRIDE * k), 8'h00, a, b);
         val = {val[23:0], b};
      end
   endtask
endmodule

// *** testbench/tb_config_rom_csr_space_decode.sv ***
// Self-checking bench for the configuration window decoder
`timescale 1ns/10ps
module tb_config_rom_csr_space_decode;
   logic CLK;
   logic RST_N;
   logic [4:0] GA;
   logic REQ;
   ccd_pkg::ccd_req_s REQ_BUS;
   logic ACK;
   logic [7:0] ACK_DATA;
   logic MODULE_EN;
   logic [1:0][31:0] FUNC_ADER;
   logic [1:0] FUNC_HIT;
   logic [7:0] RAM_OWNER;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int seed = 32'hce79;
   logic [18:0] fixed_offs [20] = '{19'h1b, 19'h1f, 19'h23, 19'h27, 19'h2b, 19'h2f, 19'hcb,
      19'hcf, 19'hd3, 19'hd7, 19'hdb, 19'hdf, 19'he03, 19'he07, 19'he0b, 19'he0f, 19'h7f,
      19'h3, 19'hfff, 19'h103};
   ccd_top #(.NUM_FUNC(2)) ccd_top_inst (.CLK(CLK), .RST_N(RST_N), .GA(GA), .REQ(REQ),
      .REQ_BUS(REQ_BUS), .ACK(ACK), .ACK_DATA(ACK_DATA), .MODULE_EN(MODULE_EN),
      .FUNC_ADER(FUNC_ADER), .FUNC_HIT(FUNC_HIT), .RAM_OWNER(RAM_OWNER));
   ccd_master ccd_master_inst (.clk(CLK), .ga(GA), .ack(ACK), .ack_data(ACK_DATA),
      .hit(FUNC_HIT[0]), .req(REQ), .req_bus(REQ_BUS));
   // Clock and hang guard
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Expected ROM byte at an offset
   function automatic logic [7:0] rom_exp(input logic [18:0] off);
      logic [18:0] sb;
      sb = ccd_pkg::SER_BEG_VAL[18:0];
      rom_exp = 8'h00;
      if (off >= sb && off <= ccd_pkg::SER_END_VAL[18:0] && off[1:0] == 2'h3) begin
         rom_exp = ccd_pkg::SERIAL_VAL[8 * (3 - int'((off - sb) >> 2)) +: 8];
      end
      case (off)
         ccd_pkg::ROM_SPEC_ID: rom_exp = ccd_pkg::SPEC_ID_VAL;
         ccd_pkg::ROM_ASCII_C: rom_exp = ccd_pkg::ASCII_C;
         ccd_pkg::ROM_ASCII_R: rom_exp = ccd_pkg::ASCII_R;
         ccd_pkg::ROM_MFR_ID: rom_exp = ccd_pkg::MFR_ID_VAL[23:16];
         ccd_pkg::ROM_MFR_ID + 19'h4: rom_exp = ccd_pkg::MFR_ID_VAL[15:8];
         ccd_pkg::ROM_MFR_ID + 19'h8: rom_exp = ccd_pkg::MFR_ID_VAL[7:0];
         ccd_pkg::ROM_SER_BEG: rom_exp = ccd_pkg::SER_BEG_VAL[23:16];
         ccd_pkg::ROM_SER_BEG + 19'h4: rom_exp = ccd_pkg::SER_BEG_VAL[15:8];
         ccd_pkg::ROM_SER_BEG + 19'h8: rom_exp = ccd_pkg::SER_BEG_VAL[7:0];
         ccd_pkg::ROM_SER_END: rom_exp = ccd_pkg::SER_END_VAL[23:16];
         ccd_pkg::ROM_SER_END + 19'h4: rom_exp = ccd_pkg::SER_END_VAL[15:8];
         ccd_pkg::ROM_SER_END + 19'h8: rom_exp = ccd_pkg::SER_END_VAL[7:0];
         default: ;
      endcase
   endfunction
   task automatic chk_rd(input logic [18:0] off, input logic [7:0] exp);
      logic a;
      logic [7:0] d;
      ccd_master_inst.cfg(1'b0, off, 8'h00, a, d);
      check("read ack", {31'h0, a}, 32'h1);
      check("read data", {24'h0, d}, {24'h0, exp});
   endtask
   task automatic wr(input logic [18:0] off, input logic [7:0] data);
      logic a;
      logic [7:0] d;
      ccd_master_inst.cfg(1'b1, off, data, a, d);
      check("write ack", {31'h0, a}, 32'h1);
      check("write data", {24'h0, d}, 32'h0);
   endtask
   task automatic rel(input logic [31:0] ader, input logic exp);
      logic a;
      logic h;
      logic [7:0] d;
      ccd_master_inst.xfer(1'b0, ader[7:2], {ader[31:16], 16'($random(seed))}, 8'h00, a, d, h);
      check("relocated hit", {31'h0, h}, {31'h0, exp});
      check("relocated ack", {31'h0, a}, 32'h0);
   endtask
   task automatic do_reset();
      RST_N = 1'b0;
      repeat (2) @(negedge CLK);
      RST_N = 1'b1;
      @(negedge CLK);
      check("enable after reset", {31'h0, MODULE_EN}, 32'h0);
      check("owner after reset", {24'h0, RAM_OWNER}, 32'h0);
      check("ader after reset", FUNC_ADER[0], 32'h0);
      check("ader 1 after reset", FUNC_ADER[1], 32'h0);
   endtask
   // Main sequence
   initial begin
      logic a;
      logic h;
      logic [7:0] d;
      logic [5:0] am;
      logic [18:0] off;
      logic [31:0] v;
      logic [31:0] ader;
      GA = 5'($random(seed));
      do_reset();
      foreach (fixed_offs[i]) chk_rd(fixed_offs[i], rom_exp(fixed_offs[i]));
      for (int i = 0; i < 40; i++) begin
         off = 19'($random(seed)) & ccd_pkg::ROM_END;
         chk_rd(off, rom_exp(off));
      end
      ccd_master_inst.rd_be(ccd_pkg::ROM_SER_BEG, 3, v);
      check("serial begin", v, {8'h0, ccd_pkg::SER_BEG_VAL});
      ccd_master_inst.rd_be(v[18:0], 4, v);
      check("serial number", v, ccd_pkg::SERIAL_VAL);
      wr(ccd_pkg::ROM_SPEC_ID, 8'($random(seed)));
      chk_rd(ccd_pkg::ROM_SPEC_ID, ccd_pkg::SPEC_ID_VAL);
      for (int i = 0; i < 8; i++) begin
         am = 6'($random(seed));
         if (am == ccd_pkg::AM_CONFIG) begin
            am = 6'h09;
         end
         ccd_master_inst.xfer(1'b0, am, {8'h00, GA, 19'h1b}, 8'h00, a, d, h);
         check("wrong code ack", {31'h0, a}, 32'h0);
         ccd_master_inst.xfer(1'b0, 6'h2f, {8'h00, GA ^ 5'(i + 1), 19'h1b}, 8'h00, a, d, h);
         check("other slot ack", {31'h0, a}, 32'h0);
         ccd_master_inst.xfer(1'b0, 6'h2f, {8'($random(seed)), GA, 19'h1b}, 8'h00, a, d, h);
         check("upper byte ignored", {23'h0, a, d}, 32'h102);
      end
      chk_rd(ccd_pkg::CSR_BAR, {GA, 3'b000});
      wr(ccd_pkg::CSR_BAR, 8'($random(seed)));
      chk_rd(ccd_pkg::CSR_BAR, {GA, 3'b000});
      ader = {16'($random(seed)), 8'h00, 6'h0d, 2'b00};
      for (int k = 0; k < 4; k++) begin
         wr(ccd_pkg::CSR_ADER_BASE + 19'(4 * k), ader[8 * (3 - k) +: 8]);
      end
      check("ader value", FUNC_ADER[0], ader);
      ccd_master_inst.rd_be(ccd_pkg::CSR_ADER_BASE, 4, v);
      check("ader readback", v, ader);
      wr(ccd_pkg::CSR_ADER_BASE + 19'(ccd_pkg::ADER_STRIDE), 8'h5c);
      check("ader 1 value", FUNC_ADER[1], 32'h5c00_0000);
      rel(ader, 1'b0);
      wr(ccd_pkg::CSR_BIT_SET, 8'h10);
      check("enable set", {31'h0, MODULE_EN}, 32'h1);
      chk_rd(ccd_pkg::CSR_BIT_CLR, 8'h10);
      rel(ader, 1'b1);
      wr(ccd_pkg::CSR_BIT_CLR, 8'h10);
      check("enable clear", {31'h0, MODULE_EN}, 32'h0);
      rel(ader, 1'b0);
      wr(ccd_pkg::CSR_RAM_OWNER, 8'h5a);
      wr(ccd_pkg::CSR_RAM_OWNER, 8'h33);
      check("owner held", {24'h0, RAM_OWNER}, 32'h5a);
      chk_rd(ccd_pkg::CSR_RAM_OWNER, 8'h5a);
      chk_rd(ccd_pkg::CSR_BIT_SET, 8'h04);
      wr(ccd_pkg::CSR_BIT_CLR, 8'h04);
      check("owner freed", {24'h0, RAM_OWNER}, 32'h0);
      d = 8'($random(seed));
      wr(ccd_pkg::RAM_START + 19'h4, d);
      chk_rd(ccd_pkg::RAM_START + 19'h4, d);
      wr(19'h40003, 8'h77);
      chk_rd(19'h40003, 8'h00);
      wr(ccd_pkg::CSR_BIT_SET, 8'h10);
      GA = GA + 5'h1;
      do_reset();
      chk_rd(ccd_pkg::CSR_BAR, {GA, 3'b000});
      print_verdict();
   end
endmodule
